// File: rtl/dcd_pkg.sv
// Constants and types shared by the download sequencer
//******************************************************************
//******************************************************************
package dcd_pkg;
	// APB register word offsets
	localparam logic [7:0] REG_CTRL = 8'h00; // Bit 0 write starts a walk
	localparam logic [7:0] REG_FLEN = 8'h04; // File length in bytes
	localparam logic [7:0] REG_STAT = 8'h08; // Busy, done, success, dead expiry
	localparam logic [7:0] REG_RESULT = 8'h0c; // Final status variable
	localparam logic [7:0] REG_PTR = 8'h10; // Current block offset
	// Block type codes
	localparam logic [31:0] BT_JUMP = 32'h0000_0001;
	localparam logic [31:0] BT_WMSG = 32'h0000_0002;
	localparam logic [31:0] BT_WNEXT = 32'h0000_0003;
	localparam logic [31:0] BT_WSPEC = 32'h0000_0004;
	localparam logic [31:0] BT_CMP = 32'h0000_0005;
	localparam logic [31:0] BT_SETCODE = 32'h0000_0006;
	localparam logic [31:0] BT_SETSTAT = 32'h0000_0007;
	localparam logic [31:0] BT_IDATA = 32'h0000_0020;
	localparam logic [31:0] BT_IPROG = 32'h0000_0021;
	localparam logic [31:0] BT_XDATA = 32'h0000_0030;
	localparam logic [31:0] BT_XPROG = 32'h0000_0031;
	// File and block layout, byte offsets
	localparam logic [31:0] OFS_FIRST_BLK = 32'd124;
	localparam logic [31:0] OFS_SKIP = 32'd4;
	localparam logic [31:0] OFS_BLK_HDR = 32'd8;
	localparam logic [31:0] OFS_4 = 32'd4;
	localparam logic [31:0] OFS_8 = 32'd8;
	localparam logic [31:0] OFS_12 = 32'd12;
	localparam logic [31:0] OFS_14 = 32'd14;
	localparam logic [31:0] OFS_MEM_ADDR = 32'd5; // Start address at 8, first sent at index 3
	localparam logic [31:0] OFS_MEM_DATA = 32'd11; // Data at 16, first sent at index 5
	// Reset and start values
	localparam logic [31:0] TMO_INIT_MS = 32'h0000_0400;
	localparam logic [15:0] STATUS_INIT = 16'h0fff;
	localparam logic [7:0] ACK_CODE = 8'h00; // Reply code taken as acknowledge
	localparam int REPLY_BYTES = 259; // Code, two control bytes, 256 payload
	// Timing
	localparam int CLK_PERIOD_NS = 4;
	localparam int MS_NS = 1000000;
	localparam int CYC_PER_MS = MS_NS / CLK_PERIOD_NS;
	typedef enum logic [4:0] {
		S_IDLE = 5'b00000, S_FETCH = 5'b00001, S_BLOCK = 5'b00010, S_TYPE = 5'b00011,
		S_SKIP = 5'b00100, S_PTRA = 5'b00101, S_PTRB = 5'b00110, S_TMOP = 5'b00111,
		S_TMO = 5'b01000, S_HIS = 5'b01001, S_GMSB = 5'b01010, S_STAT = 5'b01011,
		S_LEN = 5'b01100, S_MSG_RD = 5'b01101, S_MSG_GOT = 5'b01110, S_TX = 5'b01111,
		S_WAIT = 5'b10000, S_CMP_RD = 5'b10001, S_CMP = 5'b10010
	} dcd_state_e;
endpackage

// File: rtl/dcd_sequencer.sv
// Download file walker driving the chip mailbox, with APB control
`timescale 1ns/1ps
module dcd_sequencer #(
	parameter int CYC_PER_MS_P = dcd_pkg::CYC_PER_MS // Shorten in simulation
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata_ff,
	output logic pready_ff,
	output logic pslverr_ff,
	output logic file_rd_req_ff,
	output logic [31:0] file_addr_ff,
	input wire logic file_rd_valid,
	input wire logic [7:0] file_rd_data,
	output logic mb_tx_valid_ff,
	output logic [7:0] mb_tx_byte_ff,
	output logic mb_tx_last_ff,
	input wire logic mb_tx_ready,
	input wire logic mb_rx_valid,
	input wire logic [7:0] mb_rx_byte,
	input wire logic mb_rx_last,
	output logic done_ff,
	output logic ok_ff
);
	import dcd_pkg::*;

	//******************************************************************
	// Helpers
	//******************************************************************
	// Address of the idx-th message byte: one 16-bit word per byte
	function automatic logic [31:0] word_addr(input logic [31:0] base, input logic [31:0] ofs,
		input logic [8:0] idx);
		word_addr = base + ofs + {22'h0, idx, 1'b0};
	endfunction

	dcd_state_e state_ff; // Walker state
	dcd_state_e ret_ff; // State to resume after a fetch
	logic [31:0] flen_ff; // File length from software
	logic [31:0] cur_ff; // Current block offset
	logic [31:0] base_ff; // Start of data block
	logic [31:0] type_ff; // Block type of current block
	logic [31:0] skip_ff; // Skip pointer of current block
	logic [31:0] ptr_a_ff; // Continuation or match branch
	logic [31:0] ptr_b_ff; // Mismatch branch
	logic [31:0] g_tmo_ptr_ff; // Global expiry branch
	logic [31:0] g_tmo_ff; // Global timeout in ms
	logic [7:0] g_his_ff; // Global host-to-chip code
	logic [7:0] g_msb_ff; // Global control high byte
	logic [15:0] status_ff; // Download status variable
	logic [15:0] mlen_ff; // Memory block data word count
	logic [7:0] cnt_ff; // Payload length of current message
	logic [8:0] idx_ff; // Message byte index
	logic [31:0] acc_ff; // Fetch assembly register
	logic [31:0] f_addr_ff; // Next fetch address
	logic [2:0] f_left_ff; // Bytes left to fetch
	logic [1:0] f_lane_ff; // Byte lane of next fetched byte
	logic [31:0] tmr_cyc_ff; // Cycles within current ms
	logic [31:0] tmr_ms_ff; // Elapsed ms
	logic dead_ff; // Walk ended by expiry with no branch
	logic busy_ff; // Walk in progress
	logic [7:0] reply_buf [0:REPLY_BYTES-1]; // Latest reply, code first
	logic [8:0] rx_idx_ff; // Write index into reply store
	logic rx_evt_ff; // A whole reply arrived since last clear

	//******************************************************************
	// Decode
	//******************************************************************
	wire is_mem = (type_ff == BT_IDATA) || (type_ff == BT_IPROG) ||
		(type_ff == BT_XDATA) || (type_ff == BT_XPROG);
	wire expired = tmr_ms_ff >= g_tmo_ff;
	wire apb_acc = psel && penable && !pready_ff;
	// Writes land on the edge where the master sees pready high
	wire apb_wr = psel && penable && pready_ff && pwrite;
	wire reg_hit = (paddr == REG_CTRL) || (paddr == REG_FLEN) || (paddr == REG_STAT) ||
		(paddr == REG_RESULT) || (paddr == REG_PTR);
	wire start_cmd = apb_wr && (paddr == REG_CTRL) && pwdata[0] && !busy_ff;
	// First two header bytes of a memory write come from the globals, the third is the length count
	wire [15:0] mem_cnt16 = 16'h2 + {mlen_ff[14:0], 1'b0};
	wire [7:0] mem_const = (idx_ff == 9'd0) ? g_his_ff :
		(idx_ff == 9'd1) ? g_msb_ff : mem_cnt16[7:0];
	wire mem_hdr = is_mem && (idx_ff < 9'd3);
	// Memory write: two start address bytes, then the data bytes in file order
	wire [31:0] msg_ofs = (idx_ff < 9'd5) ? OFS_MEM_ADDR : OFS_MEM_DATA;
	wire [31:0] msg_addr = is_mem ? (base_ff + msg_ofs + {23'h0, idx_ff}) :
		word_addr(base_ff, OFS_4, idx_ff);
	wire [7:0] tx_src = mem_hdr ? mem_const : acc_ff[7:0];
	wire [7:0] tx_cnt = (idx_ff == 9'd2) ? tx_src : cnt_ff;
	wire tx_last = (idx_ff >= 9'd2) && ((idx_ff - 9'd2) == {1'b0, tx_cnt});
	wire [31:0] cmp_addr = word_addr(base_ff, (type_ff == BT_WSPEC) ? OFS_4 : OFS_8, idx_ff);
	wire [7:0] cmp_cnt = (idx_ff == 9'd2) ? acc_ff[7:0] : cnt_ff;
	wire cmp_diff = acc_ff[7:0] != reply_buf[idx_ff];
	wire cmp_last = (idx_ff >= 9'd2) && ((idx_ff - 9'd2) == {1'b0, cmp_cnt});
	wire at_end = (cur_ff >= flen_ff) || ((cur_ff + OFS_BLK_HDR) > flen_ff);
	wire rx_take = mb_rx_valid && mb_rx_last;
	wire clr_rx = (state_ff == S_PTRA && type_ff == BT_WSPEC) ||
		(state_ff == S_PTRB && type_ff == BT_WNEXT) ||
		(state_ff == S_TX && mb_tx_ready && tx_last && is_mem) ||
		(state_ff == S_WAIT && rx_evt_ff) || (state_ff == S_CMP && cmp_diff);
	wire tmr_restart = (state_ff != S_TX) && (state_ff != S_WAIT) &&
		(state_ff != S_MSG_RD) && (state_ff != S_MSG_GOT) &&
		!((state_ff == S_CMP_RD || state_ff == S_CMP || state_ff == S_FETCH) &&
		type_ff == BT_WSPEC);

	//******************************************************************
	// APB slave, one wait state
	//******************************************************************
	// Registered answer keeps bus outputs straight from flops
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= 32'h0;
			flen_ff <= 32'h0;
		end else begin
			pready_ff <= apb_acc;
			pslverr_ff <= apb_acc && !reg_hit;
			if (apb_wr && paddr == REG_FLEN) begin
				flen_ff <= pwdata;
			end
			unique case (paddr)
				REG_FLEN: prdata_ff <= flen_ff;
				REG_STAT: prdata_ff <= {28'h0, dead_ff, ok_ff, done_ff, busy_ff};
				REG_RESULT: prdata_ff <= {16'h0, status_ff};
				REG_PTR: prdata_ff <= cur_ff;
				default: prdata_ff <= 32'h0;
			endcase
		end
	end

	//******************************************************************
	// Reply capture, runs for the whole walk
	//******************************************************************
	// No reset on the store; index restarts so stale bytes are overwritten
	always_ff @(posedge clock) begin
		if (mb_rx_valid) begin
			reply_buf[rx_idx_ff] <= mb_rx_byte;
		end
	end

	// Index clamps at the last slot so an oversized reply cannot wrap
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			rx_idx_ff <= 9'h0;
			rx_evt_ff <= 1'b0;
		end else begin
			if (mb_rx_valid) begin
				rx_idx_ff <= mb_rx_last ? 9'h0 :
					(rx_idx_ff == 9'(REPLY_BYTES - 1)) ? rx_idx_ff : rx_idx_ff + 9'h1;
			end
			// Arrival wins over a clear in the same cycle
			rx_evt_ff <= rx_take | (rx_evt_ff & !clr_rx);
		end
	end

	//******************************************************************
	// Millisecond timer
	//******************************************************************
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			tmr_cyc_ff <= 32'h0;
			tmr_ms_ff <= 32'h0;
		end else if (tmr_restart) begin
			tmr_cyc_ff <= 32'h0;
			tmr_ms_ff <= 32'h0;
		end else if (tmr_cyc_ff == 32'(CYC_PER_MS_P - 1)) begin
			tmr_cyc_ff <= 32'h0;
			tmr_ms_ff <= expired ? tmr_ms_ff : tmr_ms_ff + 32'h1;
		end else begin
			tmr_cyc_ff <= tmr_cyc_ff + 32'h1;
		end
	end

	//******************************************************************
	// File walker
	//******************************************************************
	// Every field read goes through S_FETCH, low byte first
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			state_ff <= S_IDLE;
			ret_ff <= S_IDLE;
			cur_ff <= 32'h0;
			base_ff <= 32'h0;
			type_ff <= 32'h0;
			skip_ff <= 32'h0;
			ptr_a_ff <= 32'h0;
			ptr_b_ff <= 32'h0;
			g_tmo_ptr_ff <= 32'h0;
			g_tmo_ff <= TMO_INIT_MS;
			g_his_ff <= 8'h0;
			g_msb_ff <= 8'h0;
			status_ff <= STATUS_INIT;
			mlen_ff <= 16'h0;
			cnt_ff <= 8'h0;
			idx_ff <= 9'h0;
			acc_ff <= 32'h0;
			f_addr_ff <= 32'h0;
			f_left_ff <= 3'h0;
			f_lane_ff <= 2'h0;
			file_rd_req_ff <= 1'b0;
			file_addr_ff <= 32'h0;
			mb_tx_valid_ff <= 1'b0;
			mb_tx_byte_ff <= 8'h0;
			mb_tx_last_ff <= 1'b0;
			busy_ff <= 1'b0;
			done_ff <= 1'b0;
			ok_ff <= 1'b0;
			dead_ff <= 1'b0;
		end else begin
			unique case (state_ff)
				S_IDLE: if (start_cmd) begin
					// Globals and status take their start values
					g_tmo_ptr_ff <= 32'h0;
					g_tmo_ff <= TMO_INIT_MS;
					g_his_ff <= 8'h0;
					g_msb_ff <= 8'h0;
					status_ff <= STATUS_INIT;
					busy_ff <= 1'b1;
					done_ff <= 1'b0;
					ok_ff <= 1'b0;
					dead_ff <= 1'b0;
					f_addr_ff <= OFS_FIRST_BLK;
					f_left_ff <= 3'd4;
					f_lane_ff <= 2'd0;
					acc_ff <= 32'h0;
					ret_ff <= S_SKIP;
					type_ff <= 32'h0;
					state_ff <= S_FETCH;
				end
				S_FETCH: begin
					file_rd_req_ff <= 1'b1;
					file_addr_ff <= f_addr_ff;
					if (file_rd_req_ff && file_rd_valid) begin
						acc_ff[8*f_lane_ff +: 8] <= file_rd_data;
						f_lane_ff <= f_lane_ff + 2'd1;
						f_addr_ff <= f_addr_ff + 32'h1;
						file_addr_ff <= f_addr_ff + 32'h1;
						f_left_ff <= f_left_ff - 3'd1;
						if (f_left_ff == 3'd1) begin
							file_rd_req_ff <= 1'b0;
							state_ff <= ret_ff;
						end
					end
				end
				S_BLOCK: if (at_end) begin
					// Status judged only once the walk is over
					busy_ff <= 1'b0;
					done_ff <= 1'b1;
					ok_ff <= (status_ff == 16'h0);
					state_ff <= S_IDLE;
				end else begin
					f_addr_ff <= cur_ff;
					f_left_ff <= 3'd4;
					f_lane_ff <= 2'd0;
					acc_ff <= 32'h0;
					ret_ff <= S_TYPE;
					state_ff <= S_FETCH;
				end
				S_TYPE: begin
					type_ff <= acc_ff;
					f_addr_ff <= cur_ff + OFS_SKIP;
					f_left_ff <= 3'd4;
					f_lane_ff <= 2'd0;
					ret_ff <= S_SKIP;
					state_ff <= S_FETCH;
				end
				S_SKIP: if (type_ff == 32'h0) begin
					// First block offset from the file header
					cur_ff <= acc_ff;
					state_ff <= S_BLOCK;
				end else begin
					skip_ff <= acc_ff;
					base_ff <= cur_ff + OFS_BLK_HDR;
					f_addr_ff <= cur_ff + OFS_BLK_HDR;
					f_left_ff <= 3'd4;
					f_lane_ff <= 2'd0;
					ret_ff <= S_PTRA;
					state_ff <= S_FETCH;
				end
				S_PTRA: begin
					ptr_a_ff <= acc_ff;
					idx_ff <= 9'h0;
					f_left_ff <= 3'd4;
					f_lane_ff <= 2'd0;
					acc_ff <= 32'h0;
					f_addr_ff <= base_ff + OFS_4;
					if (type_ff == BT_JUMP) begin
						cur_ff <= acc_ff;
						state_ff <= S_BLOCK;
					end else if (type_ff == BT_WMSG) begin
						state_ff <= S_MSG_RD;
					end else if (type_ff == BT_WSPEC) begin
						state_ff <= S_WAIT;
					end else if (type_ff == BT_WNEXT || type_ff == BT_CMP || is_mem) begin
						ret_ff <= S_PTRB;
						state_ff <= S_FETCH;
					end else if (type_ff == BT_SETCODE) begin
						ret_ff <= S_TMOP;
						state_ff <= S_FETCH;
					end else if (type_ff == BT_SETSTAT) begin
						f_left_ff <= 3'd2;
						ret_ff <= S_STAT;
						state_ff <= S_FETCH;
					end else begin
						cur_ff <= skip_ff;
						state_ff <= S_BLOCK;
					end
				end
				S_PTRB: begin
					ptr_b_ff <= acc_ff;
					if (type_ff == BT_WNEXT) begin
						state_ff <= S_WAIT;
					end else if (type_ff == BT_CMP) begin
						state_ff <= S_CMP_RD;
					end else begin
						f_addr_ff <= base_ff + OFS_12;
						f_left_ff <= 3'd4;
						f_lane_ff <= 2'd0;
						ret_ff <= S_LEN;
						state_ff <= S_FETCH;
					end
				end
				S_TMOP: begin
					g_tmo_ptr_ff <= acc_ff;
					f_addr_ff <= base_ff + OFS_8;
					f_left_ff <= 3'd4;
					f_lane_ff <= 2'd0;
					ret_ff <= S_TMO;
					state_ff <= S_FETCH;
				end
				S_TMO: begin
					g_tmo_ff <= acc_ff;
					f_addr_ff <= base_ff + OFS_12;
					f_left_ff <= 3'd1;
					f_lane_ff <= 2'd0;
					ret_ff <= S_HIS;
					state_ff <= S_FETCH;
				end
				S_HIS: begin
					g_his_ff <= acc_ff[7:0];
					f_addr_ff <= base_ff + OFS_14;
					f_left_ff <= 3'd1;
					f_lane_ff <= 2'd0;
					ret_ff <= S_GMSB;
					state_ff <= S_FETCH;
				end
				S_GMSB: begin
					g_msb_ff <= acc_ff[7:0];
					cur_ff <= ptr_a_ff;
					state_ff <= S_BLOCK;
				end
				S_STAT: begin
					status_ff <= acc_ff[15:0];
					cur_ff <= ptr_a_ff;
					state_ff <= S_BLOCK;
				end
				S_LEN: begin
					mlen_ff <= acc_ff[15:0];
					idx_ff <= 9'h0;
					state_ff <= S_MSG_RD;
				end
				S_MSG_RD: if (mem_hdr) begin
					mb_tx_byte_ff <= tx_src;
					mb_tx_last_ff <= tx_last;
					mb_tx_valid_ff <= 1'b1;
					state_ff <= S_TX;
				end else begin
					f_addr_ff <= msg_addr;
					f_left_ff <= 3'd1;
					f_lane_ff <= 2'd0;
					ret_ff <= S_MSG_GOT;
					state_ff <= S_FETCH;
				end
				S_MSG_GOT: begin
					mb_tx_byte_ff <= tx_src;
					mb_tx_last_ff <= tx_last;
					mb_tx_valid_ff <= 1'b1;
					state_ff <= S_TX;
				end
				S_TX: if (mb_tx_ready) begin
					mb_tx_valid_ff <= 1'b0;
					cnt_ff <= tx_cnt;
					idx_ff <= idx_ff + 9'h1;
					if (!tx_last) begin
						state_ff <= S_MSG_RD;
					end else if (is_mem) begin
						state_ff <= S_WAIT;
					end else begin
						cur_ff <= ptr_a_ff;
						state_ff <= S_BLOCK;
					end
				end else if (expired) begin
					// Mailbox not released in time
					mb_tx_valid_ff <= 1'b0;
					cur_ff <= g_tmo_ptr_ff;
					dead_ff <= (g_tmo_ptr_ff == 32'h0);
					state_ff <= S_BLOCK;
				end
				S_WAIT: if (rx_evt_ff) begin
					idx_ff <= 9'h0;
					if (is_mem) begin
						cur_ff <= (reply_buf[0] == ACK_CODE) ? ptr_a_ff : ptr_b_ff;
						state_ff <= S_BLOCK;
					end else begin
						state_ff <= S_CMP_RD;
					end
				end else if (expired) begin
					cur_ff <= g_tmo_ptr_ff;
					dead_ff <= (g_tmo_ptr_ff == 32'h0);
					state_ff <= S_BLOCK;
				end
				S_CMP_RD: begin
					f_addr_ff <= cmp_addr;
					f_left_ff <= 3'd1;
					f_lane_ff <= 2'd0;
					ret_ff <= S_CMP;
					state_ff <= S_FETCH;
				end
				S_CMP: if (cmp_diff) begin
					// Specific wait drops the reply and keeps its running timer
					idx_ff <= 9'h0;
					if (type_ff == BT_WSPEC) begin
						state_ff <= S_WAIT;
					end else begin
						cur_ff <= ptr_b_ff;
						state_ff <= S_BLOCK;
					end
				end else if (cmp_last) begin
					cur_ff <= ptr_a_ff;
					state_ff <= S_BLOCK;
				end else begin
					cnt_ff <= cmp_cnt;
					idx_ff <= idx_ff + 9'h1;
					state_ff <= S_CMP_RD;
				end
				default: state_ff <= S_IDLE;
			endcase
			// A dead expiry ends the walk at once
			if (state_ff == S_BLOCK && dead_ff) begin
				busy_ff <= 1'b0;
				done_ff <= 1'b1;
				ok_ff <= 1'b0;
				state_ff <= S_IDLE;
			end
		end
	end

	//******************************************************************
	// Checks
	//******************************************************************
	a_tx_hold: assert property (@(posedge clock) disable iff (!reset_n)
		mb_tx_valid_ff && !mb_tx_ready && !expired |=> mb_tx_valid_ff && $stable(mb_tx_byte_ff))
		else $error("tx byte dropped before accept");
	a_fetch_hold: assert property (@(posedge clock) disable iff (!reset_n)
		file_rd_req_ff && !file_rd_valid |=> $stable(file_addr_ff))
		else $error("fetch address moved while waiting");
	a_status_init: assert property (@(posedge clock) disable iff (!reset_n)
		state_ff == S_IDLE && start_cmd |=> status_ff == STATUS_INIT && g_tmo_ff == TMO_INIT_MS)
		else $error("globals not initialised at start");
	a_ok_zero: assert property (@(posedge clock) disable iff (!reset_n)
		$rose(done_ff) |-> ok_ff == (status_ff == 16'h0 && !dead_ff))
		else $error("success flag disagrees with status");
	a_skip_unknown: assert property (@(posedge clock) disable iff (!reset_n)
		state_ff == S_PTRA && type_ff > BT_SETSTAT && !is_mem |=>
		state_ff == S_BLOCK && cur_ff == skip_ff)
		else $error("unknown block not skipped");
	a_jump_ptr: assert property (@(posedge clock) disable iff (!reset_n)
		state_ff == S_PTRA && type_ff == BT_JUMP |=> cur_ff == $past(acc_ff))
		else $error("jump went elsewhere");
	a_rx_event: assert property (@(posedge clock) disable iff (!reset_n)
		rx_take |=> rx_evt_ff)
		else $error("reply arrival lost");
	a_mem_hdr: assert property (@(posedge clock) disable iff (!reset_n)
		state_ff == S_MSG_RD && is_mem && idx_ff == 9'd0 |=> mb_tx_byte_ff == g_his_ff)
		else $error("memory write not using global code");
	a_no_wait_cmp: assert property (@(posedge clock) disable iff (!reset_n)
		state_ff == S_PTRB && type_ff == BT_CMP |=> state_ff == S_CMP_RD)
		else $error("compare-last waited");
endmodule

// File: tb/dcd_chip_model.sv
// Behavioural far side: download file store and chip mailbox
`timescale 1ns/1ps
module dcd_chip_model
	import dcd_pkg::*;
(
	input wire logic clock,
	input wire logic reset_n,
	input wire logic stall, // Holds mailbox busy to force expiry
	input wire logic file_rd_req,
	input wire logic [31:0] file_addr,
	output logic file_rd_valid,
	output logic [7:0] file_rd_data,
	input wire logic mb_tx_valid,
	input wire logic [7:0] mb_tx_byte,
	input wire logic mb_tx_last,
	output logic mb_tx_ready,
	output logic mb_rx_valid,
	output logic [7:0] mb_rx_byte,
	output logic mb_rx_last
);
	logic [7:0] mem [0:1023]; // File image, filled by the bench
	logic [7:0] got_q [$]; // Every byte the chip accepted
	int wait_ff; // Random file latency
	int rx_cnt_ff; // Reply bytes still to send
	//******************************************************************
	// File store: one byte per request, random latency
	//******************************************************************
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			file_rd_valid <= 1'b0;
			file_rd_data <= 8'h00;
			wait_ff <= 0;
		end else begin
			file_rd_valid <= 1'b0;
			// Released data line toggles so stale bytes never look valid
			file_rd_data <= ~file_rd_data;
			if (file_rd_req && !file_rd_valid) begin
				if (wait_ff == 0) begin
					file_rd_valid <= 1'b1;
					file_rd_data <= mem[file_addr[9:0]];
					wait_ff <= $urandom_range(2, 0);
				end else begin
					wait_ff <= wait_ff - 1;
				end
			end
		end
	end
	//******************************************************************
	// Mailbox: takes bytes, acknowledges each whole message
	//******************************************************************
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			mb_tx_ready <= 1'b0;
			mb_rx_valid <= 1'b0;
			mb_rx_last <= 1'b0;
			mb_rx_byte <= 8'h00;
			rx_cnt_ff <= 0;
		end else begin
			mb_tx_ready <= !stall && ($urandom_range(1, 0) == 1);
			mb_rx_valid <= 1'b0;
			mb_rx_last <= 1'b0;
			mb_rx_byte <= ~mb_rx_byte;
			// Reply is code, control high, control low, all zero
			if (rx_cnt_ff != 0) begin
				mb_rx_valid <= 1'b1;
				mb_rx_byte <= (rx_cnt_ff == 3) ? ACK_CODE : 8'h00;
				mb_rx_last <= (rx_cnt_ff == 1);
				rx_cnt_ff <= rx_cnt_ff - 1;
			end
			if (mb_tx_valid && mb_tx_ready) begin
				got_q.push_back(mb_tx_byte);
				if (mb_tx_last) begin
					rx_cnt_ff <= 3;
				end
			end
		end
	end
endmodule

// File: tb/tb_top.sv
// Self-checking bench: two download walks against expected results
`timescale 1ns/1ps
module tb_top;
	import dcd_pkg::*;
	logic clock, reset_n, psel, penable, pwrite, stall, perr, frq, frv, tv, tl, tr, rv, rl;
	logic pready_ff, pslverr_ff, done_ff, ok_ff;
	logic [7:0] paddr, frd, tb8, rb;
	logic [31:0] pwdata, prdata_ff, fa, rd;
	logic [15:0] w0, w1; // Random payload words
	logic [7:0] exp_q [$]; // Expected mailbox traffic
	int failures, samples_checked;
	dcd_sequencer #(.CYC_PER_MS_P(10)) dut (.clock(clock), .reset_n(reset_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata_ff(prdata_ff), .pready_ff(pready_ff), .pslverr_ff(pslverr_ff),
		.file_rd_req_ff(frq), .file_addr_ff(fa), .file_rd_valid(frv), .file_rd_data(frd),
		.mb_tx_valid_ff(tv), .mb_tx_byte_ff(tb8), .mb_tx_last_ff(tl), .mb_tx_ready(tr),
		.mb_rx_valid(rv), .mb_rx_byte(rb), .mb_rx_last(rl), .done_ff(done_ff), .ok_ff(ok_ff));
	dcd_chip_model chip (.clock(clock), .reset_n(reset_n), .stall(stall), .file_rd_req(frq),
		.file_addr(fa), .file_rd_valid(frv), .file_rd_data(frd), .mb_tx_valid(tv),
		.mb_tx_byte(tb8), .mb_tx_last(tl), .mb_tx_ready(tr), .mb_rx_valid(rv),
		.mb_rx_byte(rb), .mb_rx_last(rl));
	//******************************************************************
	// Helpers
	//******************************************************************
	task automatic complete_run();
		$display("checks %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Low byte first into the file image
	task automatic put(input int a, input logic [63:0] v, input int n);
		for (int i = 0; i < n; i++) chip.mem[a + i] = v[8 * i +: 8];
	endtask
	task automatic blk(input int a, input logic [31:0] t, input int s);
		put(a, t, 4);
		put(a + 4, s, 4);
	endtask
	// One APB transfer, held until pready is seen at an edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do begin
			@(posedge clock);
			n++;
		end while (pready_ff !== 1'b1 && n < 50);
		if (n >= 50) begin
			failures++;
			complete_run();
		end
		rd = prdata_ff;
		perr = pslverr_ff;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask
	// Start a walk and wait, bounded, for its end
	task automatic walk();
		int n;
		apb(1'b1, REG_CTRL, 32'h1);
		repeat (4) @(posedge clock);
		for (n = 0; n < 30000 && done_ff !== 1'b1; n++) @(posedge clock);
		if (n >= 30000) begin
			failures++;
			complete_run();
		end
	endtask
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	//******************************************************************
	// Main sequence
	//******************************************************************
	initial begin
		{reset_n, psel, penable, pwrite, stall, paddr, pwdata} = '0;
		failures = 0;
		samples_checked = 0;
		void'($urandom(32'hc659));
		w0 = 16'($urandom);
		w1 = 16'($urandom);
		// File: jump, unknown, set-coding, message, compare, wait, memory, status
		put(124, 128, 4);
		blk(128, BT_JUMP, 0);
		put(136, 200, 4);
		blk(200, 32'h99, 240);
		blk(240, BT_SETCODE, 0);
		put(248, 280, 4);
		put(252, 400, 4);
		put(256, 20, 4);
		put(260, 16'hc05a, 2);
		put(262, 16'h0077, 2);
		blk(280, BT_WMSG, 0);
		put(288, 320, 4);
		put(292, 16'hff12, 2);
		put(294, 16'hee34, 2);
		put(296, 16'h0002, 2);
		put(298, w0, 2);
		put(300, w1, 2);
		blk(320, BT_CMP, 0);
		put(328, {32'd600, 32'd360}, 8);
		put(336, 48'h0000_ab00_0000, 6);
		blk(360, BT_WNEXT, 0);
		put(368, {32'd600, 32'd600}, 8);
		put(376, 48'h0, 6);
		blk(400, BT_XPROG, 0);
		put(408, {32'd600, 32'd440}, 8);
		put(416, {32'd1, 32'h1234}, 8);
		put(424, 16'hc3d4, 2);
		blk(440, BT_SETSTAT, 0);
		put(448, 480, 4);
		put(452, 0, 2);
		blk(480, BT_JUMP, 0);
		put(488, 696, 4);
		blk(600, BT_SETSTAT, 0);
		put(608, 696, 4);
		put(612, 16'h0bad, 2);
		exp_q = '{8'h12, 8'h34, 8'h02, w0[7:0], w1[7:0], 8'h5a, 8'h77, 8'h04, 8'h34, 8'h12,
			8'hd4, 8'hc3};
		repeat (3) @(posedge clock);
		reset_n <= 1'b1;
		@(posedge clock);
		apb(1'b1, REG_FLEN, 32'd700);
		apb(1'b0, REG_FLEN, 32'h0);
		check(rd, 32'd700);
		apb(1'b0, 8'h20, 32'h0);
		check({rd[30:0], perr}, 32'h1);
		$display("test registers done");
		walk();
		check(chip.got_q.size(), exp_q.size());
		foreach (exp_q[i]) check(chip.got_q[i], exp_q[i]);
		apb(1'b0, REG_RESULT, 32'h0);
		check(rd, 32'h0);
		apb(1'b0, REG_STAT, 32'h0);
		check(rd, 32'h6);
		check(ok_ff, 1'b1);
		$display("test full walk done");
		// Stalled mailbox with fresh globals: expiry pointer zero ends the walk
		stall <= 1'b1;
		put(124, 280, 4);
		walk();
		check(chip.got_q.size(), exp_q.size());
		apb(1'b0, REG_RESULT, 32'h0);
		check(rd, 32'hfff);
		apb(1'b0, REG_STAT, 32'h0);
		check(rd, 32'ha);
		$display("test dead expiry done");
		complete_run();
	end
endmodule
